// ---- src/msd_decoder.sv ----
// Opcode decoder top with register slave
`timescale 1ns/1ps
module msd_decoder #(
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dec_valid,
	input wire logic [31:0] dec_instr,
	input wire msd_pkg::msd_unit_e dec_unit,
	output logic out_valid,
	output logic out_illegal,
	output msd_pkg::msd_unit_e out_unit,
	output logic out_last,
	output logic out_cnf,
	output logic [1:0] out_blk,
	output logic [1:0] out_opts,
	output logic [3:0] out_type,
	output logic [4:0] out_opc,
	output logic [4:0] out_dst,
	output logic [4:0] out_src2,
	output logic [4:0] out_src1,
	output msd_pkg::msd_sign_e m_sign,
	output logic m_int,
	output logic m_trunc,
	output logic m_sat,
	output logic m_clear,
	output logic m_round_set,
	output msd_pkg::msd_grp_e m_group,
	output logic m_single,
	output logic [1:0] m_index,
	output logic m_ext_load,
	output logic m_ext_signed,
	output logic [1:0] m_ext_type,
	output logic m_fp,
	output logic m_fp_dual,
	output msd_pkg::msd_skind_e s_kind,
	output logic s_use_imm,
	output logic [7:0] s_imm,
	output logic [7:0] s_mag_mask,
	output msd_pkg::msd_esize_e s_esize,
	output logic s_sign_ext,
	output logic s_zero_fill,
	output msd_pkg::msd_bitop_e s_bit_op,
	output msd_pkg::msd_clut_e c_tgt,
	output logic [1:0] c_size,
	output logic c_ilv,
	output logic [2:0] c_src,
	output logic x_valid,
	output logic x_ext,
	output logic x_reg_cut,
	output logic [5:0] x_cut,
	output logic x_clear,
	output logic x_xfer
);
	import msd_pkg::*;
	logic rst_a_ff, rst_b_ff;
	wire logic rst_n = rst_b_ff;
	// Reset release through two flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_a_ff <= 1'b0;
			rst_b_ff <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_b_ff <= rst_a_ff;
		end
	end

	// Software state
	logic en_ff, pend_ff, last_ill_ff;
	logic [31:0] sw_instr_ff;
	msd_unit_e sw_unit_ff;
	logic [15:0] ill_cnt_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic do_wr;
	assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// Write address and data taken in either order
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_addr_ff <= '0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_ff <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// Response one cycle after both halves held
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				unique case (aw_addr_ff)
				REG_CTRL, REG_SW_INSTR, REG_SW_ISSUE, REG_STATUS,
				REG_ILL_CNT: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Byte-lane merge of a write into a word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	logic wr_ctrl, wr_instr, wr_issue, wr_cnt;
	assign wr_ctrl = do_wr && aw_addr_ff == REG_CTRL && w_strb_ff[0];
	assign wr_instr = do_wr && aw_addr_ff == REG_SW_INSTR;
	assign wr_issue = do_wr && aw_addr_ff == REG_SW_ISSUE && w_strb_ff[0];
	assign wr_cnt = do_wr && aw_addr_ff == REG_ILL_CNT;

	// Decode source: pipeline first, then software issue
	logic pipe_go, go;
	logic [31:0] ins;
	msd_unit_e unit;
	assign pipe_go = dec_valid && en_ff;
	assign go = pipe_go || pend_ff;
	assign ins = pipe_go ? dec_instr : sw_instr_ff;
	assign unit = pipe_go ? dec_unit : sw_unit_ff;

	// Control, software instruction and issue latch
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en_ff <= CTRL_EN_RST;
			sw_instr_ff <= 32'h0000_0000;
			sw_unit_ff <= U_MULT;
			pend_ff <= 1'b0;
		end else begin
			if (wr_ctrl) en_ff <= w_data_ff[0];
			if (wr_instr)
				sw_instr_ff <= merge(sw_instr_ff, w_data_ff, w_strb_ff);
			// A new issue wins over the one being drained
			if (wr_issue) begin
				sw_unit_ff <= msd_unit_e'(w_data_ff[1:0]);
				pend_ff <= 1'b1;
			end else if (!pipe_go) begin
				pend_ff <= 1'b0;
			end
		end
	end

	// Read channel, one cycle to data
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			unique case (s_axi_araddr)
			REG_CTRL: s_axi_rdata <= {31'h0, en_ff};
			REG_SW_INSTR: s_axi_rdata <= sw_instr_ff;
			REG_SW_ISSUE: s_axi_rdata <= {30'h0, sw_unit_ff};
			REG_STATUS: s_axi_rdata <= {15'h0, pend_ff, 3'h0, out_opc,
				out_type, 1'b0, out_unit, last_ill_ff};
			REG_ILL_CNT: s_axi_rdata <= {16'h0, ill_cnt_ff};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Shifter and register-load decode
	msd_skind_e nxt_s_kind;
	logic s_ill, nxt_s_imm_en, nxt_s_sx, nxt_s_zf, nxt_c_ilv;
	logic [7:0] nxt_s_imm, nxt_s_mask;
	msd_esize_e nxt_s_es;
	msd_bitop_e nxt_s_bo;
	msd_clut_e nxt_c_tgt;
	logic [1:0] nxt_c_size;
	msd_shift_dec u_shift (
		.instr(ins),
		.kind(nxt_s_kind),
		.illegal(s_ill),
		.use_imm(nxt_s_imm_en),
		.imm_mag(nxt_s_imm),
		.mag_mask(nxt_s_mask),
		.esize(nxt_s_es),
		.sign_ext(nxt_s_sx),
		.zero_fill(nxt_s_zf),
		.bit_op(nxt_s_bo),
		.clu_tgt(nxt_c_tgt),
		.clu_size(nxt_c_size),
		.clu_ilv(nxt_c_ilv)
	);

	// Multiplier decode
	logic [3:0] t;
	logic [4:0] o, rsf, rmf;
	logic m_ill, cr_bad, nxt_int, nxt_trunc, nxt_sat, nxt_clr, nxt_rnd;
	logic nxt_single, nxt_ext, nxt_exts, nxt_fp, nxt_fpd;
	logic [1:0] nxt_idx, nxt_extt;
	msd_sign_e nxt_sign, sign_u;
	msd_grp_e nxt_grp;
	always_comb begin
		t = ins[TYPE_LSB +: 4];
		o = ins[OPC_LSB +: 5];
		rsf = ins[DST_LSB +: 5];
		rmf = ins[SRC1_LSB +: 5];
		sign_u = o[4] ? SG_UU : SG_SS;
		// clear off with round on is undefined
		cr_bad = !o[2] && o[1];
		m_ill = 1'b0;
		nxt_sign = sign_u;
		nxt_int = o[3];
		nxt_trunc = o[1] && !o[3];
		nxt_sat = 1'b0;
		nxt_clr = o[2];
		nxt_rnd = o[1];
		// pair bit chooses lower or upper
		nxt_grp = o[0] ? GR_UPPER : GR_LOWER;
		nxt_single = 1'b0;
		nxt_idx = o[1:0];
		nxt_ext = 1'b0;
		nxt_exts = 1'b0;
		nxt_extt = rsf[1:0];
		nxt_fp = 1'b0;
		nxt_fpd = 1'b0;
		unique case (t)
		TM_SS, TM_SD: begin
			unique case ({o[4], o[0]})
			2'b00: nxt_sign = SG_SS;
			2'b10: nxt_sign = SG_UU;
			2'b01: nxt_sign = SG_SU;
			default: m_ill = 1'b1;
			endcase
			nxt_clr = 1'b0;
			nxt_rnd = 1'b0;
			nxt_grp = GR_LOWER;
			if (t == TM_SS) nxt_sat = o[2];
			else m_ill = m_ill || !o[2] || o[1];
		end
		TM_DD, TM_DQ: begin
			nxt_clr = 1'b0;
			nxt_rnd = 1'b0;
			nxt_grp = GR_LOWER;
			if (t == TM_DD) nxt_sat = o[2];
			else m_ill = !o[2] || o[1];
			if (o[0]) m_ill = 1'b1;
		end
		TM_FP: begin
			nxt_fp = 1'b1;
			nxt_sign = SG_SS;
			nxt_int = 1'b0;
			nxt_trunc = o[1];
			nxt_fpd = o[0];
			nxt_clr = 1'b0;
			nxt_rnd = 1'b0;
			nxt_grp = GR_LOWER;
			m_ill = !o[4] || o[3] || o[2];
		end
		TM_ACC: m_ill = cr_bad;
		TM_ACCD: m_ill = o[1];
		TM_CX, TM_CXJ: m_ill = o[4] || cr_bad;
		TM_CXD, TM_CXJD: m_ill = o[4] || o[1];
		TM_QUAD: begin
			// quad forms; U0111 clears and rounds
			// quad forms 2, 6, 7, A and E act on all four
			unique case (o[3:0])
			4'h7, 4'h6, 4'h2, 4'hA, 4'hE: begin
				nxt_grp = GR_ALL;
				nxt_rnd = o[3:0] == 4'h7;
			end
			default: m_ill = o[1];
			endcase
		end
		TM_MRW: begin
			unique case (rsf)
			5'h00, 5'h01: m_ill = cr_bad;
			5'h02: m_ill = o[1];
			5'h03: begin
				nxt_grp = GR_ALL;
				m_ill = o[0] || cr_bad;
			end
			5'h04, 5'h05, 5'h06, 5'h07: m_ill = o[4] || cr_bad;
			5'h08: m_ill = o[4:1] != 4'h0;
			5'h0C: m_ill = o != 5'h00;
			// load with extension into fifth register
			5'h09, 5'h0A, 5'h0B: begin
				nxt_ext = 1'b1;
				nxt_exts = !o[4];
				m_ill = o[3:1] != 3'h0;
			end
			default: m_ill = 1'b1;
			endcase
			if (rsf >= 5'h08) begin
				nxt_clr = 1'b0;
				nxt_rnd = 1'b0;
			end
		end
		TM_MRR: begin
			nxt_clr = 1'b0;
			nxt_rnd = 1'b0;
			nxt_sat = o[2];
			unique case (rmf)
			5'h00, 5'h01: m_ill = o[3] || o[1];
			5'h02: begin
				nxt_grp = GR_ALL;
				m_ill = o[3] || o[1] || o[0];
			end
			5'h03: m_ill = o != 5'h01;
			5'h04: begin
				if (o[1]) nxt_grp = GR_ALL;
				m_ill = o[1] && o[0];
			end
			5'h08, 5'h09, 5'h0A: m_ill = o[3:1] != 3'h0;
			5'h0C, 5'h0D: begin
				nxt_single = 1'b1;
				m_ill = o[3:2] != 2'h0;
			end
			default: m_ill = 1'b1;
			endcase
		end
		default: m_ill = 1'b1;
		endcase
	end

	// Correlation fields
	logic is_xc, xc_ill;
	logic [5:0] cut;
	assign is_xc = unit == U_CLU && ins[TYPE_LSB+2 +: 2] == 2'b11;
	assign cut = {ins[16:15], ins[6:5], ins[1:0]};
	// register cut needs a zero cut field
	assign xc_ill = is_xc && ins[XC_RCUT_BIT] && cut != 6'h00;

	logic nxt_ill;
	always_comb begin
		unique case (unit)
		U_MULT: nxt_ill = m_ill;
		U_SHIFT: nxt_ill = s_ill;
		U_CLU: nxt_ill = xc_ill;
		default: nxt_ill = 1'b1;
		endcase
	end

	// Common fields, valid and illegal count
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_illegal <= 1'b0;
			last_ill_ff <= 1'b0;
			ill_cnt_ff <= 16'h0000;
			out_unit <= U_MULT;
			{out_last, out_cnf, out_blk, out_opts} <= 6'h00;
			{out_type, out_opc} <= 9'h000;
			{out_dst, out_src2, out_src1} <= 15'h0000;
		end else begin
			out_valid <= go;
			out_illegal <= go && nxt_ill;
			// A clearing write in the same cycle as a count leaves one
			if (go && nxt_ill) begin
				last_ill_ff <= 1'b1;
				ill_cnt_ff <= wr_cnt ? 16'h0001 : ill_cnt_ff + 16'h0001;
			end else if (go) begin
				last_ill_ff <= 1'b0;
				if (wr_cnt) ill_cnt_ff <= 16'h0000;
			end else if (wr_cnt) begin
				ill_cnt_ff <= 16'h0000;
			end
			if (go) begin
				out_unit <= unit;
				out_last <= ins[LAST_BIT];
				out_cnf <= ins[CNF_BIT];
				out_opts <= ins[OPT_LSB +: 2];
				out_blk <= ins[BLK_LSB +: 2];
				out_type <= ins[TYPE_LSB +: 4];
				out_opc <= ins[OPC_LSB +: 5];
				out_dst <= ins[DST_LSB +: 5];
				out_src2 <= ins[SRC2_LSB +: 5];
				out_src1 <= ins[SRC1_LSB +: 5];
			end
		end
	end

	// Unit specific controls, held until the next decode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			m_sign <= SG_SS;
			m_group <= GR_LOWER;
			{m_int, m_trunc, m_sat, m_clear, m_round_set} <= 5'h00;
			{m_single, m_index, m_ext_load, m_ext_signed} <= 5'h00;
			{m_ext_type, m_fp, m_fp_dual} <= 4'h0;
			s_kind <= SK_NONE;
			s_esize <= ES_WORD;
			s_bit_op <= BO_CLR;
			{s_use_imm, s_sign_ext, s_zero_fill} <= 3'h0;
			{s_imm, s_mag_mask} <= 16'h0000;
			c_tgt <= CT_NONE;
			{c_size, c_ilv, c_src} <= 6'h00;
			{x_valid, x_ext, x_reg_cut, x_clear, x_xfer} <= 5'h00;
			x_cut <= 6'h00;
		end else if (go) begin
			m_sign <= nxt_sign;
			m_group <= nxt_grp;
			{m_int, m_trunc, m_sat} <= {nxt_int, nxt_trunc, nxt_sat};
			{m_clear, m_round_set} <= {nxt_clr, nxt_clr && nxt_rnd};
			{m_single, m_index} <= {nxt_single, nxt_idx};
			{m_ext_load, m_ext_signed} <= {nxt_ext, nxt_exts};
			m_ext_type <= nxt_extt;
			{m_fp, m_fp_dual} <= {nxt_fp, nxt_fpd};
			s_kind <= nxt_s_kind;
			s_esize <= nxt_s_es;
			s_bit_op <= nxt_s_bo;
			{s_use_imm, s_sign_ext} <= {nxt_s_imm_en, nxt_s_sx};
			s_zero_fill <= nxt_s_zf;
			{s_imm, s_mag_mask} <= {nxt_s_imm, nxt_s_mask};
			c_tgt <= nxt_c_tgt;
			{c_size, c_ilv} <= {nxt_c_size, nxt_c_ilv};
			c_src <= ins[CLU_SRC_LSB +: 3];
			x_valid <= is_xc && !xc_ill;
			x_ext <= ins[XC_EXT_BIT];
			x_reg_cut <= ins[XC_RCUT_BIT];
			x_cut <= ins[XC_RCUT_BIT] ? 6'h00 : cut;
			x_clear <= ins[XC_CLR_BIT];
			x_xfer <= ins[XC_XFER_BIT];
		end
	end
endmodule

// ---- src/msd_pkg.sv ----
// Shared constants and types for the opcode decoder
package msd_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SW_INSTR = 8'h04;
	localparam logic [7:0] REG_SW_ISSUE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_ILL_CNT = 8'h10;
	// Reset values
	localparam logic CTRL_EN_RST = 1'b1;
	// Instruction field positions
	localparam int LAST_BIT = 31;
	localparam int CNF_BIT = 30;
	localparam int UNIT_LSB = 28;
	localparam int OPT_LSB = 26;
	localparam int BLK_LSB = 24;
	localparam int TYPE_LSB = 20;
	localparam int OPC_LSB = 15;
	localparam int DST_LSB = 10;
	localparam int SRC2_LSB = 5;
	localparam int SRC1_LSB = 0;
	localparam int XC_EXT_BIT = 21;
	localparam int XC_XFER_BIT = 20;
	localparam int XC_CLR_BIT = 11;
	localparam int XC_RCUT_BIT = 10;
	localparam int CLU_SRC_LSB = 7;
	localparam int CLU_SIZE_LSB = 3;
	// Multiplier type codes
	localparam logic [3:0] TM_SS = 4'h0;
	localparam logic [3:0] TM_SD = 4'h1;
	localparam logic [3:0] TM_DD = 4'h2;
	localparam logic [3:0] TM_DQ = 4'h3;
	localparam logic [3:0] TM_ACC = 4'h4;
	localparam logic [3:0] TM_ACCD = 4'h5;
	localparam logic [3:0] TM_CX = 4'h8;
	localparam logic [3:0] TM_CXD = 4'h9;
	localparam logic [3:0] TM_CXJ = 4'hA;
	localparam logic [3:0] TM_CXJD = 4'hB;
	localparam logic [3:0] TM_QUAD = 4'hC;
	localparam logic [3:0] TM_MRW = 4'hD;
	localparam logic [3:0] TM_MRR = 4'hE;
	localparam logic [3:0] TM_FP = 4'hF;
	// Shifter type codes
	localparam logic [3:0] TS_BIT = 4'hB;
	localparam logic [3:0] TS_MISC = 4'hC;
	localparam logic [3:0] TS_CLU = 4'hF;
	localparam logic [3:0] TS_SHORT = 4'h8;
	localparam logic [3:0] TS_BYTE = 4'h9;
	localparam logic [3:0] TS_SB = 4'hA;
	// Magnitude masks per element size
	localparam logic [7:0] MAG_BYTE = 8'h1F;
	localparam logic [7:0] MAG_SHORT = 8'h3F;
	localparam logic [7:0] MAG_WORD = 8'h7F;
	localparam logic [7:0] MAG_LONG = 8'hFF;
	// Communications register load opcodes
	localparam logic [4:0] CL_TRELLIS = 5'h00;
	localparam logic [4:0] CL_THR = 5'h01;
	localparam logic [4:0] CL_CTL = 5'h02;
	localparam logic [4:0] CL_THR_ILV = 5'h03;
	localparam logic [1:0] CL_SIZE_BAD = 2'h1;
	typedef enum logic [1:0] {U_MULT, U_SHIFT, U_CLU} msd_unit_e;
	typedef enum logic [1:0] {SG_SS, SG_UU, SG_SU} msd_sign_e;
	typedef enum logic [1:0] {GR_LOWER, GR_UPPER, GR_ALL} msd_grp_e;
	typedef enum logic [3:0] {SK_NONE, SK_LSHIFT, SK_ASHIFT, SK_ROT,
		SK_FIELD_EXTRACT_OP, SK_FIELD_DEPOSIT_OP, SK_MASK, SK_GETB, SK_PUTB, SK_BIT, SK_MISC,
		SK_CLU} msd_skind_e;
	typedef enum logic [1:0] {ES_BYTE, ES_SHORT, ES_WORD, ES_LONG}
		msd_esize_e;
	typedef enum logic [1:0] {BO_CLR, BO_SET, BO_TGL, BO_TST} msd_bitop_e;
	typedef enum logic [1:0] {CT_NONE, CT_TRELLIS, CT_THR, CT_CTL}
		msd_clut_e;
endpackage

// ---- src/msd_shift_dec.sv ----
// Combinational shifter and register-load field decoder
`timescale 1ns/1ps
module msd_shift_dec (
	input wire logic [31:0] instr,
	output msd_pkg::msd_skind_e kind,
	output logic illegal,
	output logic use_imm,
	output logic [7:0] imm_mag,
	output logic [7:0] mag_mask,
	output msd_pkg::msd_esize_e esize,
	output logic sign_ext,
	output logic zero_fill,
	output msd_pkg::msd_bitop_e bit_op,
	output msd_pkg::msd_clut_e clu_tgt,
	output logic [1:0] clu_size,
	output logic clu_ilv
);
	import msd_pkg::*;
	logic [3:0] typ;
	logic [4:0] o;
	logic [4:0] rn;
	logic [4:0] rsf;
	logic [4:0] key;
	// Whole decode in one process
	always_comb begin
		typ = instr[TYPE_LSB +: 4];
		o = instr[OPC_LSB +: 5];
		rn = instr[SRC2_LSB +: 5];
		rsf = instr[DST_LSB +: 5];
		key = {typ[1:0], o[4:2]};
		kind = SK_NONE;
		illegal = 1'b0;
		use_imm = o[2];
		imm_mag = {3'h0, rn};
		esize = ES_WORD;
		mag_mask = MAG_WORD;
		sign_ext = 1'b0;
		zero_fill = 1'b0;
		bit_op = msd_bitop_e'(o[4:3]);
		clu_tgt = CT_NONE;
		clu_size = instr[CLU_SIZE_LSB +: 2];
		clu_ilv = 1'b0;
		if (typ[2]) esize = instr[0] ? ES_LONG : ES_WORD;
		unique casez (typ)
		// Word and long families share one opcode table
		4'b0?00, 4'b0?01, 4'b0?10: begin
			use_imm = o[2] & ~o[4];
			if (!typ[2]) imm_mag = {2'h0, o[0], rn};
			else imm_mag = {1'b0, o[1:0], rn};
			unique casez (key)
			5'b0000?: kind = SK_LSHIFT;
			5'b0001?: kind = SK_ASHIFT;
			5'b01000: kind = SK_ROT;
			5'b01001: begin
				kind = SK_ROT;
				if (!typ[2] && o[1]) illegal = 1'b1;
			end
			5'b0101?: kind = SK_FIELD_EXTRACT_OP;
			5'b01100: kind = SK_GETB;
			5'b1000?: kind = SK_FIELD_DEPOSIT_OP;
			5'b10010: kind = SK_MASK;
			5'b10100: kind = SK_PUTB;
			default: illegal = 1'b1;
			endcase
			if ((key == 5'b01100 || key == 5'b10100) && !typ[2])
				illegal = 1'b1;
			if (kind == SK_FIELD_EXTRACT_OP || kind == SK_FIELD_DEPOSIT_OP) begin
				use_imm = 1'b0;
				sign_ext = o[0];
			end
			if (kind == SK_FIELD_DEPOSIT_OP) zero_fill = o[1];
		end
		// Short, byte and mixed element shifts
		TS_SHORT, TS_BYTE, TS_SB: begin
			kind = o[3] ? SK_ASHIFT : SK_LSHIFT;
			use_imm = o[2];
			if (typ == TS_SB) esize = instr[0] ? ES_SHORT : ES_BYTE;
			else esize = (typ == TS_BYTE) ? ES_BYTE : ES_SHORT;
			if (o[4]) illegal = 1'b1;
		end
		TS_BIT: begin
			kind = SK_BIT;
			use_imm = o[2];
			esize = o[1] ? ES_LONG : ES_WORD;
			imm_mag = o[1] ? {2'h0, o[0], rn} : {3'h0, rn};
		end
		TS_MISC: begin
			kind = SK_MISC;
			use_imm = 1'b0;
			unique case (o)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06: ;
			5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0E, 5'h0F: ;
			default: illegal = 1'b1;
			endcase
		end
		TS_CLU: begin
			kind = SK_CLU;
			use_imm = 1'b0;
			if (instr[2:0] != 3'h0 || clu_size == CL_SIZE_BAD)
				illegal = 1'b1;
			unique case (rsf)
			CL_TRELLIS: clu_tgt = CT_TRELLIS;
			CL_THR: clu_tgt = CT_THR;
			CL_THR_ILV: begin
				clu_tgt = CT_THR;
				clu_ilv = 1'b1;
			end
			CL_CTL: clu_tgt = CT_CTL;
			default: illegal = 1'b1;
			endcase
		end
		default: illegal = 1'b1;
		endcase
		unique case (esize)
		ES_BYTE: mag_mask = MAG_BYTE;
		ES_SHORT: mag_mask = MAG_SHORT;
		ES_WORD: mag_mask = MAG_WORD;
		ES_LONG: mag_mask = MAG_LONG;
		endcase
		if (typ == TS_BYTE) imm_mag = {4'h0, rn[3:0]};
		if (illegal) kind = SK_NONE;
	end
endmodule

// ---- verif/msd_monitor.sv ----
// Decode output checker bound to the decoder top
`timescale 1ns/1ps
module msd_monitor (
	input wire logic clock,
	input wire logic resetn,
	input wire logic out_valid,
	input wire logic out_illegal,
	input msd_pkg::msd_unit_e out_unit,
	input wire logic [3:0] out_type,
	input wire logic [4:0] out_opc,
	input wire logic [4:0] out_src2,
	input wire logic [4:0] out_src1,
	input wire logic m_sat,
	input msd_pkg::msd_grp_e m_group,
	input wire logic [7:0] s_imm,
	input msd_pkg::msd_bitop_e s_bit_op,
	input wire logic [1:0] c_size,
	input wire logic x_valid,
	input wire logic x_ext,
	input wire logic x_reg_cut,
	input wire logic [5:0] x_cut
);
	import msd_pkg::*;
	// Legal decode strobes for the multiplier and shifter units
	wire mu = out_valid && !out_illegal && out_unit == U_MULT;
	wire sh = out_valid && !out_illegal && out_unit == U_SHIFT;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_SAT: assert property (
		mu && out_type == TM_SS |-> m_sat == out_opc[2])
		else $error("saturation bit mismatch");
	AST_PAIR: assert property (
		mu && out_type == TM_ACC |-> m_group == msd_grp_e'({1'b0, out_opc[0]}))
		else $error("pair select mismatch");
	AST_IMM6: assert property (
		sh && out_type == 4'h0 && out_opc[4:2] == 3'b001
		|-> s_imm[5:0] == {out_opc[0], out_src2})
		else $error("six bit immediate mismatch");
	AST_BITOP: assert property (
		sh && out_type == TS_BIT |-> s_bit_op == out_opc[4:3])
		else $error("bit operation mismatch");
	AST_CLU: assert property (
		sh && out_type == TS_CLU
		|-> out_src1[2:0] == 3'b000 && c_size == out_src1[4:3])
		else $error("register load size mismatch");
	AST_EXT: assert property (
		x_valid |-> x_ext == out_type[1])
		else $error("extended accumulation mismatch");
	AST_CUT: assert property (
		x_valid && x_reg_cut |-> x_cut == 6'h00 &&
		{out_opc[1:0], out_src2[1:0], out_src1[1:0]} == 6'h00)
		else $error("register cut field not zero");
	AST_ILL: assert property (
		out_valid && out_unit == U_MULT && out_type[3:1] == 3'b011
		|-> out_illegal)
		else $error("unlisted multiplier type accepted");
endmodule
bind msd_decoder msd_monitor mon_u (.*);

// ---- verif/msd_fetch.sv ----
// Fetch pipeline model offering decode words
`timescale 1ns/1ps
module msd_fetch (
	input wire logic clock,
	output logic dec_valid,
	output logic [31:0] dec_instr,
	output msd_pkg::msd_unit_e dec_unit
);
	import msd_pkg::*;
	// Idle at time zero
	initial begin
		dec_valid = 1'b0;
		dec_instr = 32'h0000_0000;
		dec_unit = U_MULT;
	end
	// Offer one word for one cycle, then scramble the bus
	task automatic issue(input msd_unit_e u, input logic [31:0] w);
		@(posedge clock);
		dec_valid <= 1'b1;
		dec_instr <= w;
		dec_unit <= u;
		@(posedge clock);
		dec_valid <= 1'b0;
		dec_instr <= ~w;
	endtask
endmodule

// ---- verif/msd_decoder_test.sv ----
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
module msd_decoder_test;
	import msd_pkg::*;
	logic clock = 0, resetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_imm, s_mag_mask;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d, dec_instr;
	logic [3:0] s_axi_wstrb = 4'hF, out_type;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, out_blk, out_opts;
	logic [1:0] m_index, m_ext_type, c_size;
	logic dec_valid, out_valid, out_illegal, out_last, out_cnf, m_int;
	logic m_trunc, m_sat, m_clear, m_round_set, m_single, m_ext_load;
	logic m_ext_signed, m_fp, m_fp_dual, s_use_imm, s_sign_ext;
	logic s_zero_fill, c_ilv, x_valid, x_ext, x_reg_cut, x_clear, x_xfer;
	logic [2:0] c_src;
	logic [5:0] x_cut;
	logic [4:0] out_opc, out_dst, out_src2, out_src1;
	msd_unit_e dec_unit, out_unit;
	msd_sign_e m_sign;
	msd_grp_e m_group;
	msd_skind_e s_kind;
	msd_esize_e s_esize;
	msd_bitop_e s_bit_op;
	msd_clut_e c_tgt;
	int miscompares = 0, n_checks = 0;
	msd_decoder dut_u (.*);
	msd_fetch fetch_u (.clock(clock), .dec_valid(dec_valid),
		.dec_instr(dec_instr), .dec_unit(dec_unit));
	// 40 MHz clock
	always #12.5 clock = ~clock;
	task automatic chk(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bus write: both channels offered, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Bus read
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// One decode, looked at just after the result edge
	task automatic dec(input msd_unit_e u, input logic [3:0] t,
		input logic [4:0] o, d = 0, s2 = 0, s1 = 0, input logic ev = 1);
		fetch_u.issue(u, {8'h00, t, o, d, s2, s1});
		#1;
		chk("out_valid", out_valid, ev);
	endtask
	task automatic t_mult;
		logic [1:0] xy;
		for (int i = 0; i < 3; i++) begin
			xy = (i == 0) ? 2'b00 : (i == 1) ? 2'b10 : 2'b01;
			dec(U_MULT, TM_SS, {xy[1], i[0], i[1], 1'b1, xy[0]});
			chk("m_sign", m_sign, i);
			chk("m_int", m_int, i[0]);
			chk("m_trunc", m_trunc, !i[0]);
			chk("m_sat", m_sat, i[1]);
		end
	endtask
	task automatic t_mac;
		for (int i = 0; i < 3; i++) begin
			dec(U_MULT, TM_ACC, {2'b00, i != 0, i == 2, i[0]});
			chk("m_clear", m_clear, i != 0);
			chk("m_round_set", m_round_set, i == 2);
			chk("m_group", m_group, i[0]);
		end
		dec(U_MULT, TM_QUAD, 5'b00010);
		chk("quad group", m_group, GR_ALL);
		dec(U_MULT, TM_QUAD, 5'b00111);
		chk("quad round", m_round_set, 1);
		for (int j = 0; j < 2; j++) begin
			dec(U_MULT, TM_FP, {4'b1000, j[0]});
			chk("m_fp", m_fp, 1);
			chk("m_fp_dual", m_fp_dual, j[0]);
		end
		dec(U_MULT, TM_MRW, 5'b10000, 5'h0A);
		chk("ext load", {m_ext_load, m_ext_signed, m_ext_type}, 4'hA);
		dec(U_MULT, TM_MRR, 5'b00010, 0, 0, 5'h0C);
		chk("one result", {m_single, m_index}, 3'h6);
	endtask
	task automatic t_shift;
		for (int k = 0; k < 4; k++) begin
			dec(U_SHIFT, TS_BIT, {k[1:0], k[0], 2'b00});
			chk("s_bit_op", s_bit_op, k);
			chk("s_use_imm", s_use_imm, k[0]);
			chk("s_kind", s_kind, SK_BIT);
		end
		dec(U_SHIFT, 4'h0, 5'b00101, 0, 5'h13);
		chk("s_imm", s_imm, 8'h33);
		dec(U_SHIFT, 4'h0, 5'b00000);
		chk("word mask", s_mag_mask, MAG_WORD);
		dec(U_SHIFT, TS_BYTE, 5'b00000);
		chk("byte mask", s_mag_mask, MAG_BYTE);
		dec(U_SHIFT, 4'h4, 5'b00111, 0, 5'h05, 5'h01);
		chk("s_imm7", s_imm, 8'h65);
		chk("long size", s_esize, ES_LONG);
		chk("long mask", s_mag_mask, MAG_LONG);
		dec(U_SHIFT, TS_SB, 5'b00000, 0, 0, 5'h01);
		chk("sb size", s_esize, ES_SHORT);
		dec(U_SHIFT, 4'h2, 5'b00010);
		chk("field_deposit_op opts", {s_sign_ext, s_zero_fill}, 2'b01);
		fetch_u.issue(U_SHIFT, 32'hDB00_5553);
		#1;
		chk("top bits", {out_last, out_cnf, out_opts, out_blk}, 6'h3B);
		chk("operands", {out_dst, out_src2, out_src1}, 15'h5553);
	endtask
	task automatic t_clu;
		logic [4:0] op[3] = '{5'h00, 5'h03, 5'h02};
		logic [1:0] sz[3] = '{2'b11, 2'b10, 2'b00};
		msd_clut_e tg[3] = '{CT_TRELLIS, CT_THR, CT_CTL};
		for (int n = 0; n < 3; n++) begin
			dec(U_SHIFT, TS_CLU, 0, op[n], {n[2:0], 2'b00}, {sz[n], 3'b000});
			chk("c_src", c_src, n);
			chk("c_tgt", c_tgt, tg[n]);
			chk("c_ilv", c_ilv, n == 1);
			chk("c_size", c_size, sz[n]);
		end
		dec(U_SHIFT, TS_CLU, 0, 5'h00, 0, 5'b11001);
		chk("load low bits", out_illegal, 1);
		dec(U_MULT, 4'h6, 5'b00000);
		chk("mult type 6", out_illegal, 1);
		dec(U_CLU, 4'hE, 0, 5'h01);
		chk("x_reg_cut", {x_reg_cut, x_valid}, 2'b11);
		chk("x_ext", x_ext, 1);
		dec(U_CLU, 4'hC, 5'h01, 0, 5'h02, 5'h03);
		chk("x_cut", x_cut, 6'h1B);
		chk("x_ext off", x_ext, 0);
		dec(U_CLU, 4'hC, 0, 5'h01, 0, 5'h01);
		chk("cut field", {out_illegal, x_valid}, 2'b10);
	endtask
	// Enable gating, illegal count and unmapped places
	task automatic t_regs;
		rd(REG_CTRL);
		chk("ctrl reset", rd_d[0], CTRL_EN_RST);
		wr(REG_CTRL, 32'h0000_0000);
		dec(U_MULT, TM_SS, 5'b00000, 0, 0, 0, 0);
		wr(REG_CTRL, 32'h0000_0001);
		rd(REG_ILL_CNT);
		chk("ill count", rd_d, 3);
		wr(REG_ILL_CNT, 32'h0000_0000);
		rd(REG_ILL_CNT);
		chk("ill cleared", rd_d, 0);
		rd(8'h40);
		chk("unmapped read", rsp, 2'h2);
		wr(8'h40, 32'h0000_0000);
		chk("unmapped write", rsp, 2'h2);
		wr(REG_SW_INSTR, {8'h00, TM_FP, 5'b10001, 15'h0000});
		wr(REG_SW_ISSUE, 32'h0000_0000);
		#1;
		chk("sw issue", {out_valid, m_fp, m_fp_dual}, 3'h7);
		rd(REG_STATUS);
		chk("status", rd_d, 32'h0000_11F0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		t_mult;
		t_mac;
		t_shift;
		t_clu;
		t_regs;
		report_and_stop;
	end
	// Hang guard, well beyond the roughly 120 cycles used
	initial begin
		#100000;
		miscompares++;
		report_and_stop;
	end
endmodule
